// *** src/sfc_core.sv ***
// Command side of a serial flash: setup word, status, write latch, protection.
// Assumes serial pins are asynchronous to mclk and much slower than it.
`default_nettype none
// What this block does
// R1: Setup word bits 15:12 values 1..14 give that many dummy clocks.
// R2: Field 0000 or 1111 gives ten quad, eight dual and standard.
// R3: Setup bit 0 picks address width at power-up; one is 3-byte.
// R4: Host writes ones into setup bits 11:5 and 3:1.
// R5: Host sends write enable, write-setup command, then sixteen bits.
// R6: Host value pattern is 1110 111y xxxx 1111.
// R7: Setup word travels low byte first, then high byte.
// R8: External programmer chooses dummy count and width for its scheme.
// R9: Setup read shifts sixteen bits, then zeros.
// R10: Raising chip select ends a setup read at any time.
// R11: Write disable clears the write enable latch.
// R12: Latch clears at power-up and on completed writes and erases; setup writes leave it set.
// R13: Read status returns status register serially.
// R14: Write-in-progress reads one while program or erase runs.
// R15: Program or erase rejected while the latch is zero.
// R16: Host sets the latch before each write or erase.
// R17: Top/bottom bit zero protects high sectors, one low sectors.
// R18: Bulk erase runs only with all protect bits zero.
// R19: Writes and sector erases into protected sectors are refused.
// R20: Top map: 1 sector, 2, 4, 8, 16, then all.
// R21: Bottom map: sector 0, 0-1, 0-3, 0-7, 0-15, then all.
// R22: Bits travel MSB first; opcodes 05, 04 and B1.
// R23: Write commands not ending on a byte boundary are discarded.
module sfc_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial link
  input wire logic serial_clock_pin,
  input wire logic chip_select_n,
  input wire logic serial_line_zero,
  output logic serial_line_one_o,
  output logic serial_line_one_oe,
  // Memory core handshake
  output logic op_start_r,
  output logic [7:0] op_code_r,
  output logic [31:0] op_addr_r,
  input wire logic op_done,
  // Setup and status view
  output logic addr_four_byte_r,
  output logic [3:0] dummy_fast_r,
  output logic [3:0] dummy_quad_r,
  output logic [7:0] status_r
);
  // ==========================================
  // Pin synchronisers
  logic [2:0] sclk_r;
  logic [2:0] cs_r;
  logic [1:0] din_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_r <= 3'h0;
      cs_r <= 3'h7;
      din_r <= 2'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], serial_clock_pin};
      cs_r <= {cs_r[1:0], chip_select_n};
      din_r <= {din_r[0], serial_line_zero};
    end
  end
  wire logic sclk_rise;
  wire logic sclk_fall;
  wire logic sel;
  wire logic cs_end;
  wire logic din;
  assign sel = ~cs_r[1];
  assign sclk_rise = sel & sclk_r[1] & ~sclk_r[2];
  assign sclk_fall = sel & ~sclk_r[1] & sclk_r[2];
  assign cs_end = cs_r[1] & ~cs_r[2];
  assign din = din_r[1];
  // ==========================================
  // Registers
  sfc_pkg::sfc_state_e state_r, state_nxt;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] opc_r;
  logic [31:0] addr_r;
  logic [2:0] addr_cnt_r;
  logic [1:0] data_cnt_r;
  logic [15:0] cfg_r;
  logic [15:0] cfg_new_r;
  logic [3:0] prot_new_r;
  logic [3:0] prot_r;
  logic wel_r;
  logic wip_r;
  logic init_done_r;
  logic [15:0] out_sh_r;
  logic out_rotate_r;
  // ==========================================
  // Map instance
  sfc_map_if mif ();
  sfc_map u_map (.m(mif.map));
  assign mif.protect_size = prot_r[2:0];
  assign mif.protect_from_bottom = prot_r[3];
  assign mif.sector = addr_r[sfc_pkg::SECTOR_HI:sfc_pkg::SECTOR_LO];
  assign mif.dummy_code = cfg_r[sfc_pkg::CFG_DUMMY_HI:sfc_pkg::CFG_DUMMY_LO];
  // ==========================================
  // Decode
  wire logic [7:0] byte_in;
  wire logic byte_done;
  wire logic [2:0] addr_bytes;
  wire logic opc_prog;
  wire logic opc_erase_sec;
  wire logic addr_last;
  wire logic whole_bytes;
  wire logic may_write;
  wire logic [7:0] status_now;
  assign byte_in = {shift_r[6:0], din}; // R22
  assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);
  assign addr_bytes = addr_four_byte_r ? 3'h4 : 3'h3;
  assign addr_last = (addr_cnt_r == addr_bytes - 3'h1);
  assign opc_prog = (opc_r == sfc_pkg::OPC_WR_BYTES) || (opc_r == sfc_pkg::OPC_WR_DUAL) ||
    (opc_r == sfc_pkg::OPC_WR_QUAD);
  assign opc_erase_sec = (opc_r == sfc_pkg::OPC_ERASE_SECTOR);
  assign whole_bytes = (bit_cnt_r == 3'h0); // R23
  assign may_write = wel_r & ~wip_r & whole_bytes; // R15
  assign status_now = {2'h0, prot_r, wel_r, wip_r};
  always_comb begin
    state_nxt = state_r;
    if (byte_done) begin
      case (state_r)
        sfc_pkg::SFC_OPCODE: begin
          case (byte_in)
            sfc_pkg::OPC_RD_STATUS, sfc_pkg::OPC_RD_SETUP: state_nxt = sfc_pkg::SFC_RDOUT;
            sfc_pkg::OPC_WR_STATUS, sfc_pkg::OPC_WR_SETUP: state_nxt = sfc_pkg::SFC_WDATA;
            sfc_pkg::OPC_WR_BYTES, sfc_pkg::OPC_WR_DUAL, sfc_pkg::OPC_WR_QUAD,
            sfc_pkg::OPC_ERASE_SECTOR: state_nxt = sfc_pkg::SFC_ADDR;
            default: state_nxt = sfc_pkg::SFC_SKIP;
          endcase
        end
        sfc_pkg::SFC_ADDR: begin
          if (addr_last) begin
            state_nxt = opc_prog ? sfc_pkg::SFC_WDATA : sfc_pkg::SFC_SKIP;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
  end
  // ==========================================
  // Command commit at chip select release
  wire logic commit_wel_set;
  wire logic commit_wel_clr;
  wire logic commit_status;
  wire logic commit_setup;
  wire logic commit_op;
  wire logic op_allowed;
  assign commit_wel_set = cs_end && (opc_r == sfc_pkg::OPC_WR_ENABLE) &&
    (state_r == sfc_pkg::SFC_SKIP) && ~wip_r && whole_bytes;
  assign commit_wel_clr = cs_end && (opc_r == sfc_pkg::OPC_WR_DISABLE) &&
    (state_r == sfc_pkg::SFC_SKIP) && ~wip_r && whole_bytes; // R11
  assign commit_status = cs_end && may_write && (opc_r == sfc_pkg::OPC_WR_STATUS) &&
    (state_r == sfc_pkg::SFC_WDATA) && (data_cnt_r != 2'h0);
  assign commit_setup = cs_end && may_write && (opc_r == sfc_pkg::OPC_WR_SETUP) &&
    (state_r == sfc_pkg::SFC_WDATA) && (data_cnt_r == 2'h2); // R5
  assign op_allowed = (opc_prog && (state_r == sfc_pkg::SFC_WDATA) &&
      (data_cnt_r != 2'h0) && ~mif.is_protected) || // R19
    (opc_erase_sec && (state_r == sfc_pkg::SFC_SKIP) && ~mif.is_protected) || // R19
    ((opc_r == sfc_pkg::OPC_ERASE_BULK) && (state_r == sfc_pkg::SFC_SKIP) &&
      (prot_r[2:0] == 3'h0)); // R18
  assign commit_op = cs_end && may_write && op_allowed; // R15
  // ==========================================
  // Link state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= sfc_pkg::SFC_OPCODE;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      opc_r <= 8'h00;
      addr_r <= 32'h0000_0000;
      addr_cnt_r <= 3'h0;
      data_cnt_r <= 2'h0;
      cfg_new_r <= sfc_pkg::CFG_RST;
      prot_new_r <= sfc_pkg::ST_PROT_RST;
    end else if (!sel) begin
      state_r <= sfc_pkg::SFC_OPCODE; // R10
      bit_cnt_r <= 3'h0;
      addr_cnt_r <= 3'h0;
      data_cnt_r <= 2'h0;
    end else if (sclk_rise) begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= byte_in;
      if (byte_done && state_r == sfc_pkg::SFC_OPCODE) begin
        opc_r <= byte_in;
      end
      if (byte_done && state_r == sfc_pkg::SFC_ADDR) begin
        addr_r <= {addr_r[23:0], byte_in};
        addr_cnt_r <= addr_cnt_r + 3'h1;
      end
      if (byte_done && state_r == sfc_pkg::SFC_WDATA) begin
        if (data_cnt_r != 2'h3) begin
          data_cnt_r <= data_cnt_r + 2'h1;
        end
        if (data_cnt_r == 2'h0) begin
          cfg_new_r[7:0] <= byte_in; // R7
          prot_new_r <= byte_in[sfc_pkg::ST_FROM_BOTTOM:sfc_pkg::ST_BP_LO];
        end
        if (data_cnt_r == 2'h1) begin
          cfg_new_r[15:8] <= byte_in; // R7
        end
      end
    end
  end
  // ==========================================
  // Status, setup word and memory handshake
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wel_r <= 1'b0; // R12
      wip_r <= 1'b0;
      prot_r <= sfc_pkg::ST_PROT_RST;
      cfg_r <= sfc_pkg::CFG_RST;
      op_start_r <= 1'b0;
      op_code_r <= 8'h00;
      op_addr_r <= 32'h0000_0000;
    end else begin
      op_start_r <= commit_op;
      if (commit_op) begin
        wip_r <= 1'b1; // R14
        op_code_r <= opc_r;
        op_addr_r <= addr_four_byte_r ? addr_r : {8'h00, addr_r[23:0]};
      end else if (op_done) begin
        wip_r <= 1'b0; // R14
      end
      if (commit_wel_set) begin
        wel_r <= 1'b1;
      end else if (commit_wel_clr || commit_status || (op_done && wip_r)) begin
        wel_r <= 1'b0; // R11 R12
      end
      if (commit_status) begin
        prot_r <= prot_new_r;
      end
      if (commit_setup) begin
        cfg_r <= cfg_new_r;
      end
    end
  end
  // ==========================================
  // Views of setup word and status
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      init_done_r <= 1'b0;
      addr_four_byte_r <= 1'b0;
      dummy_fast_r <= sfc_pkg::DUMMY_DEF_FAST;
      dummy_quad_r <= sfc_pkg::DUMMY_DEF_QUAD;
      status_r <= 8'h00;
    end else begin
      init_done_r <= 1'b1;
      if (!init_done_r) begin
        addr_four_byte_r <= ~cfg_r[sfc_pkg::CFG_ADDR_SEL]; // R3
      end
      dummy_fast_r <= mif.dummy_fast; // R1 R2
      dummy_quad_r <= mif.dummy_quad; // R1 R2
      status_r <= status_now;
    end
  end
  // ==========================================
  // Serial output
  wire logic load_out;
  assign load_out = byte_done && (state_r == sfc_pkg::SFC_OPCODE);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_sh_r <= 16'h0000;
      out_rotate_r <= 1'b0;
      serial_line_one_o <= 1'b0;
      serial_line_one_oe <= 1'b0;
    end else begin
      serial_line_one_oe <= sel && (state_r == sfc_pkg::SFC_RDOUT);
      if (!sel) begin
        serial_line_one_o <= 1'b0;
      end else if (load_out) begin
        out_rotate_r <= (byte_in == sfc_pkg::OPC_RD_STATUS);
        out_sh_r <= (byte_in == sfc_pkg::OPC_RD_STATUS) ? {status_now, status_now} : // R13
          {cfg_r[7:0], cfg_r[15:8]}; // R7 R9
      end else if (sclk_fall && state_r == sfc_pkg::SFC_RDOUT) begin
        serial_line_one_o <= out_sh_r[15]; // R22
        out_sh_r <= {out_sh_r[14:0], out_rotate_r & out_sh_r[15]}; // R9 R13
      end
    end
  end
endmodule
`default_nettype wire

// *** src/sfc_map.sv ***
// Block-protection map for the 32-sector array and dummy-count decode.
// Assumes inputs stable within the mclk domain; purely combinational.
`default_nettype none
module sfc_map (
  // Carrier
  sfc_map_if.map m
);
  // ==========================================
  // Protected region size
  wire logic [5:0] prot_len;
  wire logic [5:0] sector_w;
  wire logic dummy_default;
  assign prot_len = (m.protect_size == 3'h0) ? 6'h00 :
    (m.protect_size >= sfc_pkg::BP_ALL_MIN) ? sfc_pkg::SECTOR_COUNT :
    6'(6'h01 << (m.protect_size - 3'h1));
  assign sector_w = {1'b0, m.sector};
  assign m.is_protected = m.protect_from_bottom ? (sector_w < prot_len) : // R17 R21
    (sector_w >= 6'(sfc_pkg::SECTOR_COUNT - prot_len)); // R20
  // ==========================================
  // Dummy cycles
  assign dummy_default = (m.dummy_code == sfc_pkg::DUMMY_ZERO) ||
    (m.dummy_code == sfc_pkg::DUMMY_ONES);
  assign m.dummy_fast = dummy_default ? sfc_pkg::DUMMY_DEF_FAST : m.dummy_code; // R1 R2
  assign m.dummy_quad = dummy_default ? sfc_pkg::DUMMY_DEF_QUAD : m.dummy_code; // R1 R2
endmodule
`default_nettype wire

// *** src/sfc_map_if.sv ***
// Carrier between the command core and the protection/dummy map.
// Assumes both ends sit in the mclk domain; contents are combinational.
`default_nettype none
interface sfc_map_if;
  logic [2:0] protect_size;
  logic protect_from_bottom;
  logic [4:0] sector;
  logic [3:0] dummy_code;
  logic is_protected;
  logic [3:0] dummy_fast;
  logic [3:0] dummy_quad;
  modport core (output protect_size, protect_from_bottom, sector, dummy_code,
    input is_protected, dummy_fast, dummy_quad);
  modport map (input protect_size, protect_from_bottom, sector, dummy_code,
    output is_protected, dummy_fast, dummy_quad);
endinterface
`default_nettype wire

// *** src/sfc_pkg.sv ***
// Constants shared by the flash command block and its protection map.
// Assumes a single mclk domain; serial pins are synchronised inside sfc_core.
`default_nettype none
package sfc_pkg;
  // ==========================================
  // Opcodes
  localparam logic [7:0] OPC_RD_STATUS = 8'h05;
  localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
  localparam logic [7:0] OPC_WR_STATUS = 8'h01;
  localparam logic [7:0] OPC_RD_SETUP = 8'hB5;
  localparam logic [7:0] OPC_WR_SETUP = 8'hB1;
  localparam logic [7:0] OPC_WR_BYTES = 8'h02;
  localparam logic [7:0] OPC_WR_DUAL = 8'hD2;
  localparam logic [7:0] OPC_WR_QUAD = 8'h12;
  localparam logic [7:0] OPC_ERASE_BULK = 8'hC7;
  localparam logic [7:0] OPC_ERASE_SECTOR = 8'hD8;
  // ==========================================
  // Status register fields
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 4;
  localparam int ST_FROM_BOTTOM = 5;
  localparam logic [3:0] ST_PROT_RST = 4'h0;
  // ==========================================
  // Setup word fields and defaults
  localparam int CFG_DUMMY_HI = 15;
  localparam int CFG_DUMMY_LO = 12;
  localparam int CFG_ADDR_SEL = 0;
  localparam logic [15:0] CFG_RST = 16'hFFFF;
  localparam logic [3:0] DUMMY_ZERO = 4'h0;
  localparam logic [3:0] DUMMY_ONES = 4'hF;
  localparam logic [3:0] DUMMY_DEF_FAST = 4'h8;
  localparam logic [3:0] DUMMY_DEF_QUAD = 4'hA;
  // ==========================================
  // Array geometry
  localparam int SECTOR_HI = 20;
  localparam int SECTOR_LO = 16;
  localparam logic [5:0] SECTOR_COUNT = 6'h20;
  localparam logic [2:0] BP_ALL_MIN = 3'h6;
  typedef enum {
    SFC_OPCODE, SFC_ADDR, SFC_WDATA, SFC_RDOUT, SFC_SKIP
  } sfc_state_e;
endpackage
`default_nettype wire

// *** testbench/sfc_core_checker.sv ***
// Port assertions for the flash command block.
// Assumes it is bound onto sfc_core; one mclk domain.
`default_nettype none
module sfc_core_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Watched ports
  input wire logic chip_select_n,
  input wire logic serial_line_one_oe,
  input wire logic op_start_r,
  input wire logic [7:0] op_code_r,
  input wire logic [31:0] op_addr_r,
  input wire logic op_done,
  input wire logic [3:0] dummy_fast_r,
  input wire logic [3:0] dummy_quad_r,
  input wire logic [7:0] status_r
);
  // ==========================================
  // Protected span and target sector
  wire logic [2:0] psize = status_r[4:2];
  wire logic [5:0] span = (psize >= 3'h6) ? 6'h20 :
    (psize == 3'h0) ? 6'h00 : 6'h01 << (psize - 3'h1);
  wire logic [5:0] sec = {1'b0, op_addr_r[20:16]};
  wire logic prog = op_start_r && (op_code_r inside {sfc_pkg::OPC_WR_BYTES,
    sfc_pkg::OPC_WR_DUAL, sfc_pkg::OPC_WR_QUAD, sfc_pkg::OPC_ERASE_SECTOR});
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================
  // Assertions
  AST_OE_RELEASE: assert property (serial_line_one_oe |-> !$past(chip_select_n, 6))
    else $error("data driven without select");
  AST_START_WEL: assert property (op_start_r |-> status_r[1])
    else $error("operation started with latch clear");
  AST_START_PULSE: assert property (op_start_r |=> !op_start_r)
    else $error("start longer than one cycle");
  AST_WIP_SET: assert property (op_start_r |-> ##[1:3] status_r[0])
    else $error("busy bit not set");
  AST_DONE_CLEAR: assert property (op_done && status_r[0] |-> ##[1:3] status_r[1:0] == 2'h0)
    else $error("busy or latch not cleared");
  AST_BULK: assert property (op_start_r && op_code_r == sfc_pkg::OPC_ERASE_BULK
    |-> psize == 3'h0)
    else $error("bulk erase while protected");
  AST_PROT_TOP: assert property (prog && !status_r[5] |-> sec < 6'h20 - span)
    else $error("write into protected top sector");
  AST_PROT_BOT: assert property (prog && status_r[5] |-> sec >= span)
    else $error("write into protected bottom sector");
  AST_DUMMY_DEF: assert property (dummy_fast_r != dummy_quad_r |->
    dummy_fast_r == 4'h8 && dummy_quad_r == 4'hA)
    else $error("dummy counts differ off default");
  AST_DUMMY_CODE: assert property (!(dummy_fast_r inside {4'h0, 4'hF}))
    else $error("dummy count out of range");
endmodule
bind sfc_core sfc_core_checker i_sfc_core_checker (.mclk(mclk), .reset(reset),
  .chip_select_n(chip_select_n), .serial_line_one_oe(serial_line_one_oe),
  .op_start_r(op_start_r), .op_code_r(op_code_r), .op_addr_r(op_addr_r),
  .op_done(op_done), .dummy_fast_r(dummy_fast_r), .dummy_quad_r(dummy_quad_r),
  .status_r(status_r));
`default_nettype wire

// *** testbench/sfc_host.sv ***
// Host model driving the serial link, mode 0, MSB first.
// Assumes mclk from the bench; serial clock period 20 mclk.
`default_nettype none
module sfc_host (
  // Clock
  input wire logic mclk,
  // Serial link
  output logic serial_clock_pin,
  output logic chip_select_n,
  output logic serial_line_zero,
  input wire logic serial_line_one_o,
  input wire logic serial_line_one_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clock_pin = 1'b0;
    chip_select_n = 1'b1;
    serial_line_zero = 1'b0;
  end
  // ==========================================
  // Frame tasks
  task automatic half();
    repeat (10) @(negedge mclk);
  endtask
  task automatic sel();
    @(negedge mclk);
    chip_select_n = 1'b0;
    half();
  endtask
  task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
    for (int i = 0; i < n; i++) begin
      serial_line_zero = b[7 - i];
      half();
      serial_clock_pin = 1'b1;
      r = {r[6:0], serial_line_one_oe ? serial_line_one_o : 1'bz};
      half();
      serial_clock_pin = 1'b0;
    end
  endtask
  task automatic desel();
    half();
    chip_select_n = 1'b1;
    serial_line_zero = ~serial_line_zero;
    repeat (8) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for sfc_core with the host model.
// Assumes the checker binds itself onto sfc_core.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset, sclk, cs_n, mosi, miso, miso_oe, op_start_r, op_done;
  logic addr_four_byte_r;
  logic [7:0] op_code_r, status_r;
  logic [31:0] op_addr_r;
  logic [3:0] dummy_fast_r, dummy_quad_r, c;
  logic [23:0] g;
  int n_fail = 0;
  int check_count = 0;
  int n_start = 0;
  int n0, span;
  int cycles = 0;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  sfc_core i_sfc_core (.mclk(mclk), .reset(reset), .serial_clock_pin(sclk),
    .chip_select_n(cs_n), .serial_line_zero(mosi), .serial_line_one_o(miso),
    .serial_line_one_oe(miso_oe), .op_start_r(op_start_r), .op_code_r(op_code_r),
    .op_addr_r(op_addr_r), .op_done(op_done), .addr_four_byte_r(addr_four_byte_r),
    .dummy_fast_r(dummy_fast_r), .dummy_quad_r(dummy_quad_r), .status_r(status_r));
  sfc_host i_sfc_host (.mclk(mclk), .serial_clock_pin(sclk), .chip_select_n(cs_n),
    .serial_line_zero(mosi), .serial_line_one_o(miso), .serial_line_one_oe(miso_oe));
  // ==========================================
  // Memory core stand-in and timeout
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (op_start_r === 1'b1) n_start <= n_start + 1;
  end
  initial begin
    op_done = 1'b0;
    forever begin
      @(posedge mclk iff op_start_r === 1'b1);
      repeat (20) @(negedge mclk);
      op_done = 1'b1;
      @(negedge mclk);
      op_done = 1'b0;
    end
  end
  always @(negedge mclk) begin
    if (cycles == 80000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ==========================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input int n, input logic [39:0] d);
    logic [7:0] r;
    i_sfc_host.sel();
    for (int i = n - 1; i >= 0; i--) begin
      i_sfc_host.shift(d[8 * i +: 8], 8, r);
      g = {g[15:0], r};
    end
    i_sfc_host.desel();
  endtask
  task automatic wren();
    cmd(1, 40'(sfc_pkg::OPC_WR_ENABLE));
  endtask
  task automatic starts(input string what, input int add);
    repeat (30) @(negedge mclk);
    check(what, 16'(n0 + add), 16'(n_start));
  endtask
  task automatic erase(input int sec, input int ok);
    n0 = n_start;
    wren();
    cmd(4, {8'h00, sfc_pkg::OPC_ERASE_SECTOR, 3'h0, 5'(sec), 16'h0000});
    starts("sector erase", ok);
  endtask
  // ==========================================
  // Tests
  initial begin
    logic [7:0] r, opc;
    reset = 1'b1;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    check("status", 16'h0000, {8'h00, status_r});
    check("dummy", 16'h08A0, {4'h0, dummy_fast_r, dummy_quad_r, 4'h0});
    check("four byte", 16'h0000, {15'h0, addr_four_byte_r});
    $display("test reset done");
    wren();
    cmd(3, {16'h0, sfc_pkg::OPC_RD_STATUS, 16'h0});
    check("status read", 16'h0202, g[15:0]);
    cmd(1, 40'(sfc_pkg::OPC_WR_DISABLE));
    cmd(2, {24'h0, sfc_pkg::OPC_RD_STATUS, 8'h0});
    check("latch cleared", 16'h0000, {8'h00, g[7:0]});
    cmd(4, {8'h0, sfc_pkg::OPC_RD_SETUP, 24'h0});
    check("setup read", 16'hFFFF, g[23:8]);
    check("setup tail", 16'h0000, {8'h00, g[7:0]});
    $display("test status done");
    for (int k = 0; k < 7; k++) begin
      c = (k == 0) ? 4'h1 : (k == 1) ? 4'h5 : (k == 2) ? 4'hE : (k == 3) ? 4'h0 :
        (k == 4) ? 4'hC : (k == 5) ? 4'h4 : 4'hF;
      wren();
      cmd(3, {16'h0, sfc_pkg::OPC_WR_SETUP, 8'hEF, c, 4'hF});
      check("fast", {12'h0, (c == 4'h0 || c == 4'hF) ? 4'h8 : c}, 16'(dummy_fast_r));
      check("quad", {12'h0, (c == 4'h0 || c == 4'hF) ? 4'hA : c}, 16'(dummy_quad_r));
    end
    cmd(3, {16'h0, sfc_pkg::OPC_RD_SETUP, 16'h0});
    check("setup back", 16'hEFFF, g[15:0]);
    $display("test setup done");
    cmd(1, 40'(sfc_pkg::OPC_WR_DISABLE));
    n0 = n_start;
    cmd(5, {sfc_pkg::OPC_WR_BYTES, 24'h000100, 8'h5A});
    starts("no latch", 0);
    wren();
    cmd(5, {sfc_pkg::OPC_WR_BYTES, 24'h000100, 8'h5A});
    starts("program", 1);
    check("opcode", 16'h0002, {8'h00, op_code_r});
    check("addr", 16'h0100, op_addr_r[15:0]);
    check("after done", 16'h0000, {8'h00, status_r});
    for (int q = 0; q < 2; q++) begin
      opc = q ? sfc_pkg::OPC_WR_QUAD : sfc_pkg::OPC_WR_DUAL;
      n0 = n_start;
      wren();
      cmd(5, {opc, 24'h1F0000, 8'h5A});
      starts("lane program", 1);
      check("lane opcode", {8'h00, opc}, {8'h00, op_code_r});
      check("lane addr", 16'h001F, op_addr_r[31:16]);
      check("lane done", 16'h0000, {8'h00, status_r});
    end
    wren();
    n0 = n_start;
    i_sfc_host.sel();
    i_sfc_host.shift(sfc_pkg::OPC_WR_BYTES, 8, r);
    repeat (3) i_sfc_host.shift(8'h00, 8, r);
    i_sfc_host.shift(8'hA5, 8, r);
    i_sfc_host.shift(8'h5A, 7, r);
    i_sfc_host.desel();
    starts("partial byte", 0);
    $display("test program done");
    for (int t = 0; t < 2; t++) begin
      for (int b = 1; b < 8; b++) begin
        span = (b >= 6) ? 32 : 1 << (b - 1);
        wren();
        cmd(2, {24'h0, sfc_pkg::OPC_WR_STATUS, 2'b00, 1'(t), 3'(b), 2'b00});
        check("protect", {10'h0, 1'(t), 3'(b), 2'b00}, {8'h00, status_r});
        erase(t ? span - 1 : 32 - span, 0);
        if (span < 32) erase(t ? span : 31 - span, 1);
        n0 = n_start;
        wren();
        cmd(1, 40'(sfc_pkg::OPC_ERASE_BULK));
        starts("bulk refused", 0);
      end
    end
    wren();
    cmd(2, {24'h0, sfc_pkg::OPC_WR_STATUS, 8'h00});
    n0 = n_start;
    wren();
    cmd(1, 40'(sfc_pkg::OPC_ERASE_BULK));
    starts("bulk", 1);
    $display("test protect done");
    report_and_stop();
  end
endmodule
`default_nettype wire
